// *** logic/serial_slave_top.sv ***
/*
 * synchronous slave serial unit with apb registers and sleep wake-up.
 * assumes the external master drives the clock pin; the core reports
 * sleep on i_sleep in this clock domain.
 */
// Design decisions made here: the APB register port and the placing of the registers.
// What this block does
// - shifting only runs in synchronous slave mode
// - shift registers step on external clock only
// - reading rx data clears rx complete flag
// - pins accepted at once when sleeping
// - full received word sets rx complete flag
// - wake and optional call to vector 004h set in the same cycle
// - tx data write clears buffer empty flag
// - tx wake needs tx and peripheral enables
// - tx bits shifted out with external clocks
// - buffer moves to shifter, then flag sets
// - emptied buffer takes a new character
// - sync set, clock source clear, enable set: slave
// - receive with continuous or single enable set, else transmit
// - overrun cleared by dropping continuous or port enable
`timescale 1ns/10ps
module serial_slave_top
    import serial_pkg::*;
#(
    parameter int W = WORD_W                      // serial word width
) (
    input  wire logic              I_CLK,         // system clock, 250 MHz
    input  wire logic              I_RST_N,       // async reset, active low
    input  wire logic              I_PSEL,        // apb select
    input  wire logic              I_PENABLE,     // apb access phase
    input  wire logic              I_PWRITE,      // apb direction
    input  wire logic [ADDR_W-1:0] I_PADDR,       // apb byte address
    input  wire logic [31:0]       I_PWDATA,      // apb write data
    output logic [31:0]            O_PRDATA,      // apb read data
    output logic                   O_PREADY,      // apb ready
    output logic                   O_PSLVERR,     // apb error, unmapped
    input  wire logic              I_SLEEP,       // core is asleep
    input  wire logic              I_SCK,         // serial_clock_pin in
    input  wire logic              I_SDA,         // serial_data_pin in
    output logic                   O_SDA,         // serial_data_pin out
    output logic                   O_SDA_OE,      // serial_data_pin drive
    output logic                   O_WAKE,        // wake request
    output logic                   O_ISR_CALL,    // call handler
    output logic [VEC_W-1:0]       O_ISR_VECTOR   // handler address
);
    if (W > 32) begin : g_bad_width
        $error("serial_slave_top needs W of 32 or less");
    end

    // ==========================================================
    // decode helper
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] ofs);
        return a == ofs;
    endfunction

    serial_link_if #(.W(W)) lk ();                // link to shifter

    logic [1:0]        sck_sync_q;   // clock pin synchroniser
    logic [1:0]        sda_sync_q;   // data pin synchroniser
    logic              sck_prev_q;   // last synced clock
    logic [CTRL_W-1:0] ctrl_q;       // mode control
    logic [IEN_W-1:0]  ien_q;        // irq enables
    logic              rx_flag_q;    // rx_complete_flag
    logic              tx_flag_q;    // tx_buffer_empty_flag
    logic              ovr_q;        // overrun_error_flag
    logic [W-1:0]      rx_data_q;    // rx_data_register
    logic [W-1:0]      tx_buf_q;     // tx_data_register
    logic              buf_full_q;   // buffer holds a word
    logic [31:0]       prdata_q;     // read data
    logic              pready_q;     // ready
    logic              pslverr_q;    // error
    logic              wake_q;       // wake request
    logic              call_q;       // handler call
    logic              oe_q;         // pin drive enable

    // ==========================================================
    // bus decode
    wire        access   = I_PSEL & I_PENABLE;
    wire        take     = access & ~pready_q;    // cycle before answer
    wire        exec     = access & pready_q;     // transfer completes
    wire        wr_exec  = exec & I_PWRITE;
    wire        rd_exec  = exec & ~I_PWRITE;
    wire        sel_ctrl = hit(I_PADDR, CTRL_OFS);
    wire        sel_ien  = hit(I_PADDR, IEN_OFS);
    wire        sel_flg  = hit(I_PADDR, FLG_OFS);
    wire        sel_txd  = hit(I_PADDR, TXD_OFS);
    wire        sel_rxd  = hit(I_PADDR, RXD_OFS);
    wire        mapped   = sel_ctrl | sel_ien | sel_flg | sel_txd | sel_rxd;
    wire        tx_wr    = wr_exec & sel_txd;
    wire        rx_rd    = rd_exec & sel_rxd;

    // ==========================================================
    // mode decode
    wire        port_en    = ctrl_q[CTRL_PORT];
    wire        cont_rx    = ctrl_q[CTRL_CONT];
    wire        slave_mode = ctrl_q[CTRL_SYNC] & ~ctrl_q[CTRL_MCLK] & port_en;
    wire        rx_mode    = cont_rx | ctrl_q[CTRL_ONCE];
    wire        tx_mode    = ~rx_mode;

    // ==========================================================
    // data flow decode
    wire        xfer    = buf_full_q & ~lk.tx_busy & ~tx_wr
                          & slave_mode & tx_mode;
    wire        rx_new  = lk.rx_done;
    wire        rx_take = rx_new & (~rx_flag_q | rx_rd);
    wire        ovr_evt = rx_new & rx_flag_q & ~rx_rd;
    wire        rx_req  = rx_flag_q & ien_q[IEN_RX] & ien_q[IEN_PERI];
    wire        tx_req  = tx_flag_q & ien_q[IEN_TX] & ien_q[IEN_PERI];
    wire        irq_req = rx_req | tx_req;

    wire [FLG_W-1:0] flg_vec;
    assign flg_vec[FLG_RX]   = rx_flag_q;
    assign flg_vec[FLG_TX]   = tx_flag_q;
    assign flg_vec[FLG_OVR]  = ovr_q;
    assign flg_vec[FLG_BUSY] = lk.tx_busy;

    wire [31:0] rd_word = sel_ctrl ? 32'(ctrl_q)    :
                          sel_ien  ? 32'(ien_q)     :
                          sel_flg  ? 32'(flg_vec)   :
                          sel_rxd  ? 32'(rx_data_q) : 32'h0000_0000;

    // ==========================================================
    // pin synchronisers and clock edge finder
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            sck_sync_q <= 2'h0;
            sda_sync_q <= 2'h0;
            sck_prev_q <= 1'b0;
        end else begin
            sck_sync_q <= {sck_sync_q[0], I_SCK};
            sda_sync_q <= {sda_sync_q[0], I_SDA};
            sck_prev_q <= sck_sync_q[1];
        end
    end

    // link drive: edges stand whether asleep or not
    assign lk.en       = slave_mode;
    assign lk.tx_mode  = tx_mode;
    assign lk.sck_rise = sck_sync_q[1] & ~sck_prev_q;
    assign lk.sck_fall = ~sck_sync_q[1] & sck_prev_q;
    assign lk.din      = sda_sync_q[1];
    assign lk.tx_load  = xfer;
    assign lk.tx_word  = tx_buf_q;

    serial_shifter #(.W(W)) u_shifter (
        .i_clk   (I_CLK),
        .i_rst_n (I_RST_N),
        .lk      (lk.shifter)
    );

    // ==========================================================
    // apb answer, one wait state
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= take;
            pslverr_q <= take & ~mapped;
            prdata_q  <= (take & ~I_PWRITE) ? rd_word : 32'h0000_0000;
        end
    end

    // control and enable registers
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            ctrl_q <= CTRL_RST;
            ien_q  <= IEN_RST;
        end else if (wr_exec) begin
            if (sel_ctrl) ctrl_q <= I_PWDATA[CTRL_W-1:0];
            if (sel_ien)  ien_q  <= I_PWDATA[IEN_W-1:0];
        end
    end

    // ==========================================================
    // receive side: flag set wins over read clear
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rx_flag_q <= 1'b0;
            rx_data_q <= '0;
            ovr_q     <= 1'b0;
        end else if (!port_en) begin
            rx_flag_q <= 1'b0;
            ovr_q     <= 1'b0;
        end else begin
            rx_flag_q <= rx_take | (rx_flag_q & ~rx_rd);
            ovr_q     <= ovr_evt | (ovr_q & cont_rx);
            if (rx_take) rx_data_q <= lk.rx_word;
        end
    end

    // ==========================================================
    // transmit side: buffer then shifter
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            tx_flag_q  <= TXF_RST;
            buf_full_q <= 1'b0;
            tx_buf_q   <= '0;
        end else if (!port_en) begin
            tx_flag_q  <= TXF_RST;
            buf_full_q <= 1'b0;
        end else begin
            tx_flag_q  <= xfer | (tx_flag_q & ~tx_wr);
            buf_full_q <= tx_wr | (buf_full_q & ~xfer);
            if (tx_wr) tx_buf_q <= I_PWDATA[W-1:0];
        end
    end

    // ==========================================================
    // wake, handler call and pin drive
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            wake_q <= 1'b0;
            call_q <= 1'b0;
            oe_q   <= 1'b0;
        end else begin
            wake_q <= I_SLEEP & irq_req;
            call_q <= irq_req & ien_q[IEN_GLOB];
            oe_q   <= slave_mode & tx_mode;
        end
    end

    assign O_PRDATA     = prdata_q;
    assign O_PREADY     = pready_q;
    assign O_PSLVERR    = pslverr_q;
    assign O_SDA        = lk.dout;
    assign O_SDA_OE     = oe_q;
    assign O_WAKE       = wake_q;
    assign O_ISR_CALL   = call_q;
    assign O_ISR_VECTOR = ISR_VEC;

    // ==========================================================
    // checks
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);

    rx_set_a: assert property (port_en && rx_new |=> rx_flag_q)
        else $error("rx flag not set by a received word");
    rx_read_a: assert property (port_en && rx_rd && !rx_new |=> !rx_flag_q)
        else $error("rx data read did not clear flag");
    tx_clr_a: assert property (port_en && tx_wr |=> !tx_flag_q && buf_full_q)
        else $error("tx write did not clear empty flag");
    tx_move_a: assert property (port_en && xfer |=> tx_flag_q ##1 lk.tx_busy)
        else $error("buffer move did not set flag");
    tx_take_a: assert property (port_en && tx_wr
        |=> tx_buf_q == $past(I_PWDATA[W-1:0]))
        else $error("new character not taken");
    tx_wake_a: assert property (I_SLEEP && tx_flag_q && !ien_q[IEN_PERI]
        && !rx_req |=> !O_WAKE)
        else $error("tx wake without peripheral enable");
    isr_call_a: assert property (O_WAKE && $past(ien_q[IEN_GLOB]) |-> O_ISR_CALL)
        else $error("wake with global enable but no call");
    ovr_clr_a: assert property (!cont_rx && !rx_new |=> !ovr_q)
        else $error("overrun kept after enable cleared");
    rx_no_oe_a: assert property (rx_mode |=> !O_SDA_OE)
        else $error("pin driven in receive mode");
    rx_edge_a: assert property (I_SLEEP && slave_mode && rx_mode
        && sck_sync_q[1] && !sck_prev_q |-> lk.sck_rise)
        else $error("clock edge lost in sleep");
    cv_rx_word: cover property (rx_new ##[1:40] rx_rd);
    cv_overrun: cover property (ovr_evt);
    cv_two_pending: cover property (lk.tx_busy && buf_full_q && I_SLEEP);
    cv_wake: cover property (I_SLEEP ##1 O_WAKE);
endmodule

// *** logic/serial_pkg.sv ***
/*
 * constants shared by the synchronous slave serial unit:
 * register offsets, field positions, reset values, vector address.
 * assumes an 8-bit APB address and 32-bit APB data.
 */
package serial_pkg;
    // ==========================================================
    // widths
    localparam int          WORD_W     = 8;       // serial word width
    localparam int          ADDR_W     = 8;       // apb address width
    localparam int          CTRL_W     = 5;       // control field count
    localparam int          IEN_W      = 4;       // enable field count
    localparam int          FLG_W      = 4;       // flag field count
    localparam int          VEC_W      = 13;      // program address width
    // ==========================================================
    // register byte offsets
    localparam logic [7:0]  CTRL_OFS   = 8'h00;   // mode control
    localparam logic [7:0]  IEN_OFS    = 8'h04;   // irq enables
    localparam logic [7:0]  FLG_OFS    = 8'h08;   // flags, read only
    localparam logic [7:0]  TXD_OFS    = 8'h0c;   // tx_data_register
    localparam logic [7:0]  RXD_OFS    = 8'h10;   // rx_data_register
    // ==========================================================
    // control fields
    localparam int          CTRL_SYNC  = 0;       // synchronous mode
    localparam int          CTRL_MCLK  = 1;       // clock_source_master_select
    localparam int          CTRL_PORT  = 2;       // serial_port_enable
    localparam int          CTRL_CONT  = 3;       // continuous_rx_enable
    localparam int          CTRL_ONCE  = 4;       // single_rx_enable
    // enable fields
    localparam int          IEN_RX     = 0;       // rx_irq_enable
    localparam int          IEN_TX     = 1;       // tx_irq_enable
    localparam int          IEN_PERI   = 2;       // peripheral_irq_master_enable
    localparam int          IEN_GLOB   = 3;       // global_irq_enable
    // flag fields
    localparam int          FLG_RX     = 0;       // rx_complete_flag
    localparam int          FLG_TX     = 1;       // tx_buffer_empty_flag
    localparam int          FLG_OVR    = 2;       // overrun_error_flag
    localparam int          FLG_BUSY   = 3;       // tx shifter busy
    // ==========================================================
    // reset values and vector
    localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
    localparam logic [IEN_W-1:0]  IEN_RST  = 4'h0;
    localparam logic              TXF_RST  = 1'b1;  // buffer empty
    localparam logic [VEC_W-1:0]  ISR_VEC  = 13'h0004;
endpackage

// *** logic/serial_link_if.sv ***
/*
 * bundle between the register side and the shift engine.
 * assumes both ends run on the same system clock.
 */
`timescale 1ns/10ps
interface serial_link_if #(parameter int W = 8);
    logic         en;        // slave mode active
    logic         tx_mode;   // transmit direction
    logic         sck_rise;  // external clock rising, one cycle
    logic         sck_fall;  // external clock falling, one cycle
    logic         din;       // synchronised data pin
    logic         tx_load;   // move buffer word into shifter
    logic [W-1:0] tx_word;   // word to load
    logic         tx_busy;   // shifter holds a word
    logic         tx_done;   // last bit clocked out, pulse
    logic         rx_done;   // word complete, pulse
    logic [W-1:0] rx_word;   // received word
    logic         dout;      // data pin drive value
    // ==========================================================
    modport regs (output en, tx_mode, sck_rise, sck_fall, din, tx_load, tx_word,
                  input  tx_busy, tx_done, rx_done, rx_word, dout);
    modport shifter (input  en, tx_mode, sck_rise, sck_fall, din, tx_load, tx_word,
                     output tx_busy, tx_done, rx_done, rx_word, dout);
endinterface

// *** logic/serial_shifter.sv ***
/*
 * shift engine: rx and tx shift registers stepped by external clock edges.
 * assumes edge pulses and data come in already synchronised, lsb first.
 */
`timescale 1ns/10ps
module serial_shifter
    import serial_pkg::*;
#(
    parameter int W = WORD_W                // word width
) (
    input  wire logic       i_clk,          // system clock
    input  wire logic       i_rst_n,        // async reset, active low
    serial_link_if.shifter  lk              // link to register side
);
    localparam int          CW   = $clog2(W);
    localparam logic [CW-1:0] LAST = CW'(W - 1);

    if (W < 2) begin : g_bad_width
        $error("serial_shifter needs W of 2 or more");
    end

    logic [W-1:0]  rx_sr_q;   // rx_shift_register
    logic [W-1:0]  tx_sr_q;   // tx_shift_register
    logic [CW-1:0] rcnt_q;    // rx bit count
    logic [CW-1:0] tcnt_q;    // tx bit count
    logic          busy_q;    // tx word in flight
    logic          dout_q;    // data pin value
    logic          rxd_q;     // rx done pulse
    logic          txd_q;     // tx done pulse
    wire           rx_on   = lk.en & ~lk.tx_mode;
    wire           tx_on   = lk.en & lk.tx_mode;
    wire           rx_last = rx_on & lk.sck_rise & (rcnt_q == LAST);
    wire           tx_last = tx_on & busy_q & lk.sck_fall & (tcnt_q == LAST);

    // ==========================================================
    // receive: sample on rising edges only
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_sr_q <= '0;
            rcnt_q  <= '0;
        end else if (!rx_on) begin
            rcnt_q <= '0;
        end else if (lk.sck_rise) begin
            rx_sr_q <= {lk.din, rx_sr_q[W-1:1]};
            rcnt_q <= (rcnt_q == LAST) ? '0 : rcnt_q + 1'b1;
        end
    end

    // ==========================================================
    // transmit: next bit put out on falling edges
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_sr_q <= '0;
            tcnt_q  <= '0;
            busy_q  <= 1'b0;
            dout_q  <= 1'b0;
        end else if (!tx_on) begin
            busy_q <= 1'b0;
            tcnt_q <= '0;
        end else if (lk.tx_load && !busy_q) begin
            tx_sr_q <= lk.tx_word;
            busy_q <= 1'b1;
            tcnt_q <= '0;
            dout_q <= lk.tx_word[0];
        end else if (busy_q && lk.sck_fall) begin
            if (tcnt_q == LAST) begin
                busy_q <= 1'b0;
            end else begin
                tx_sr_q <= tx_sr_q >> 1;
                dout_q  <= tx_sr_q[1];
                tcnt_q <= tcnt_q + 1'b1;
            end
        end
    end

    // done pulses, one cycle each
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rxd_q <= 1'b0;
            txd_q <= 1'b0;
        end else begin
            rxd_q <= rx_last;
            txd_q <= tx_last;
        end
    end

    assign lk.rx_word = rx_sr_q;
    assign lk.rx_done = rxd_q;
    assign lk.tx_done = txd_q;
    assign lk.tx_busy = busy_q;
    assign lk.dout    = dout_q;

    // ==========================================================
    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    rx_hold_a: assert property (!lk.sck_rise |=> $stable(rx_sr_q))
        else $error("rx shift moved without a clock edge");
    idle_clr_a: assert property (!lk.en |=> !busy_q && rcnt_q == '0)
        else $error("shifter active outside slave mode");
    tx_bit_a: assert property (busy_q && tx_on && lk.sck_fall && tcnt_q != LAST
        |=> dout_q == $past(tx_sr_q[1]))
        else $error("tx bit not advanced on falling edge");
    cv_tx_done: cover property (txd_q);
endmodule

// *** sim/sync_master_model.sv ***
/*
 * external synchronous master: makes the shift clock, sends and takes words.
 * assumes the device samples on rising and shifts after falling clock edges.
 */
`timescale 1ns/10ps
module sync_master_model (
    output logic      o_sck,   // shift clock to device
    output logic      o_sda,   // data to device
    input  wire logic i_sda    // data from device
);
    // ==========================================
    // clock idles low, still between frames
    initial begin
        o_sck = 1'b0;
        o_sda = 1'b0;
    end
    // send one word lsb first, 64 ns per bit
    task automatic send_word(input logic [7:0] w);
        for (int k = 0; k < 8; k++) begin
            o_sda = w[k];
            #32 o_sck = 1'b1;
            #32 o_sck = 1'b0;
        end
        o_sda = ~w[7]; // driven to the inverse of the last bit: no stale level
    endtask
    // take one word, sampled at each rising edge
    task automatic recv_word(output logic [7:0] w);
        for (int k = 0; k < 8; k++) begin
            #32 o_sck = 1'b1;
            w[k] = i_sda;
            #32 o_sck = 1'b0;
        end
    endtask
endmodule

// *** sim/tb.sv ***
/*
 * self-checking bench for the slave serial unit, apb master inside.
 * assumes the master model is the only driver of clock and data pins.
 */
`timescale 1ns/10ps
module tb;
    import serial_pkg::*;
    logic I_CLK = 0, I_RST_N = 0, I_PSEL = 0, I_PENABLE = 0, I_PWRITE = 0;
    logic [7:0] I_PADDR = 0;
    logic [31:0] I_PWDATA = 0, O_PRDATA, rdat;
    logic O_PREADY, O_PSLVERR, I_SLEEP = 0, sck, sdi, O_SDA, O_SDA_OE;
    logic O_WAKE, O_ISR_CALL, serr;
    logic [12:0] O_ISR_VECTOR;
    logic [7:0] w;
    int fail_count = 0, total_checks = 0, cyc = 0;
    always #2 I_CLK = ~I_CLK;
    serial_slave_top serial_slave_top_i (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
        .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE),
        .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
        .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_SLEEP(I_SLEEP),
        .I_SCK(sck), .I_SDA(sdi), .O_SDA(O_SDA), .O_SDA_OE(O_SDA_OE),
        .O_WAKE(O_WAKE), .O_ISR_CALL(O_ISR_CALL), .O_ISR_VECTOR(O_ISR_VECTOR));
    sync_master_model sync_master_model_i (.o_sck(sck), .o_sda(sdi), .i_sda(O_SDA));
    // ==========================================
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer, waits for ready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge I_CLK);
        I_PSEL <= 1; I_PWRITE <= wr; I_PADDR <= a; I_PWDATA <= d;
        @(posedge I_CLK);
        I_PENABLE <= 1;
        do begin
            @(posedge I_CLK);
            n++;
        end while (O_PREADY !== 1'b1 && n < 20);
        if (O_PREADY !== 1'b1) fail_count++;
        rdat = O_PRDATA;
        serr = O_PSLVERR;
        I_PSEL <= 0; I_PENABLE <= 0;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge I_CLK);
    endtask
    task automatic wait_wake();
        for (int k = 0; k < 50 && O_WAKE !== 1'b1; k++) @(posedge I_CLK);
    endtask
    // ==========================================
    // reset values and unmapped access
    task automatic t_reset();
        apb(0, CTRL_OFS, 0); chk(rdat, 0);
        apb(0, FLG_OFS, 0); chk(rdat & 32'hb, 32'h2);
        apb(0, 8'h20, 0); chk({31'h0, serr}, 1);
        chk({19'h0, O_ISR_VECTOR}, 32'h4);
        $display("reset test done");
    endtask
    // receive in sleep, wake, then unload
    task automatic t_rx_sleep();
        apb(1, CTRL_OFS, 32'h0d); apb(1, IEN_OFS, 32'h0d);
        I_SLEEP <= 1;
        chk({31'h0, O_SDA_OE}, 0);
        sync_master_model_i.send_word(8'ha5);
        wait_wake();
        chk({31'h0, O_WAKE}, 1); chk({31'h0, O_ISR_CALL}, 1);
        I_SLEEP <= 0;
        apb(0, FLG_OFS, 0); chk(rdat & 32'h1, 32'h1);
        apb(0, RXD_OFS, 0); chk(rdat, 32'ha5);
        apb(0, FLG_OFS, 0); chk(rdat & 32'h1, 0);
        $display("rx sleep test done");
    endtask
    // overrun cleared by dropping continuous enable; single enable receives
    task automatic t_overrun();
        sync_master_model_i.send_word(8'h11);
        sync_master_model_i.send_word(8'h22);
        idle(8);
        apb(0, FLG_OFS, 0); chk(rdat & 32'h5, 32'h5);
        apb(1, CTRL_OFS, 32'h05);
        apb(0, FLG_OFS, 0); chk(rdat & 32'h4, 0);
        apb(0, RXD_OFS, 0); chk(rdat, 32'h11);
        apb(1, CTRL_OFS, 32'h15);
        sync_master_model_i.send_word(8'h81);
        idle(8);
        apb(0, RXD_OFS, 0); chk(rdat, 32'h81);
        $display("overrun test done");
    endtask
    // two words pending, refill after the buffer moves
    task automatic t_tx_sleep();
        apb(1, CTRL_OFS, 32'h05); apb(1, IEN_OFS, 32'h02);
        apb(1, TXD_OFS, 32'h3c); apb(1, TXD_OFS, 32'hc3);
        apb(0, FLG_OFS, 0); chk(rdat & 32'h2, 0);
        chk({31'h0, O_SDA_OE}, 1);
        I_SLEEP <= 1;
        sync_master_model_i.recv_word(w); chk({24'h0, w}, 32'h3c);
        idle(10);
        chk({31'h0, O_WAKE}, 0);
        apb(1, IEN_OFS, 32'h06);
        wait_wake();
        chk({31'h0, O_WAKE}, 1); chk({31'h0, O_ISR_CALL}, 0);
        apb(0, FLG_OFS, 0); chk(rdat & 32'h2, 32'h2);
        apb(1, TXD_OFS, 32'h5a);
        apb(0, FLG_OFS, 0); chk(rdat & 32'h2, 0);
        sync_master_model_i.recv_word(w); chk({24'h0, w}, 32'hc3);
        idle(4);
        sync_master_model_i.recv_word(w); chk({24'h0, w}, 32'h5a);
        I_SLEEP <= 0;
        $display("tx sleep test done");
    endtask
    // master clock source selected: no shifting
    task automatic t_not_slave();
        apb(1, CTRL_OFS, 32'h0f);
        sync_master_model_i.send_word(8'h33);
        idle(8);
        apb(0, FLG_OFS, 0); chk(rdat & 32'h1, 0);
        $display("not slave test done");
    endtask
    // ==========================================
    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge I_CLK) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fail_count++;
            report_and_stop();
        end
    end
    initial begin
        idle(4);
        I_RST_N <= 1;
        t_reset();
        t_rx_sleep();
        t_overrun();
        t_tx_sleep();
        t_not_slave();
        report_and_stop();
    end
endmodule
